// [dpio_ext_pins.sv]
/* Far-side pin model: peripherals drive every pin the port leaves undriven.
 Assumes one instance per port. */
`timescale 1ns/100ps
module dpio_ext_pins (
   input wire [7:0] pinOut,
   input wire [7:0] pinOe,
   input wire [7:0] extDrive,
   output wire [7:0] pinLevel
);
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule // dpio_ext_pins

// [dpio_map.vh]
/*
 Register map, mode codes and reset values of the dual address/IO port block.
 Assumes the CPU bus presents 16-bit byte addresses.
*/
`ifndef DPIO_MAP_VH
`define DPIO_MAP_VH
`define DPIO_LOW_DIR_ADDR 16'hFF85
`define DPIO_LOW_DATA_ADDR 16'hFF87
`define DPIO_HIGH_DIR_ADDR 16'hFF88
`define DPIO_HIGH_DATA_ADDR 16'hFF8A
`define DPIO_DIR_RESET 8'h00
`define DPIO_DATA_RESET 8'h00
`define DPIO_DIR_READ 8'hFF
`define DPIO_UNMAPPED_READ 8'hFF
`define DPIO_MODE1 3'h1
`define DPIO_MODE2 3'h2
`define DPIO_MODE3 3'h3
`define DPIO_MODE4 3'h4
`define DPIO_MODE7 3'h7
`endif

// [dpio_ports.v]
/*
 Two 8-bit memory-mapped ports: low port doubles as address 7..0, high port as address 15..8.
 Assumes a simple synchronous CPU register port and a mode code held stable by the chip.
*/
`timescale 1ns/100ps
`include "dpio_map.vh"
module dpio_ports #(
   parameter WIDTH = 8
) (
   input wire ref_clk,
   input wire arst_n,
   input wire hwStandby,
   input wire softStandby,
   input wire [2:0] mode,
   input wire [15:0] busAddr,
   input wire [15:0] regAddr,
   input wire regWrite,
   input wire regRead,
   input wire [WIDTH-1:0] regWdata,
   output reg [WIDTH-1:0] regRdata,
   output reg regRvalid,
   input wire [WIDTH-1:0] lowPinIn,
   output reg [WIDTH-1:0] lowPinOut,
   output reg [WIDTH-1:0] lowPinOe,
   input wire [WIDTH-1:0] highPinIn,
   output reg [WIDTH-1:0] highPinOut,
   output reg [WIDTH-1:0] highPinOe,
   output reg [WIDTH-1:0] highPullUp
);
   // Register state and next values
   reg [WIDTH-1:0] lowDir;
   reg [WIDTH-1:0] lowData;
   reg [WIDTH-1:0] highDir;
   reg [WIDTH-1:0] highData;
   reg [WIDTH-1:0] next_lowDir;
   reg [WIDTH-1:0] next_lowData;
   reg [WIDTH-1:0] next_highDir;
   reg [WIDTH-1:0] next_highData;

   // Synchronised pin levels
   wire [WIDTH-1:0] lowPinSync;
   wire [WIDTH-1:0] highPinSync;

   // Next values of the registered outputs
   reg [WIDTH-1:0] next_lowPinOut;
   reg [WIDTH-1:0] next_lowPinOe;
   reg [WIDTH-1:0] next_highPinOut;
   reg [WIDTH-1:0] next_highPinOe;
   reg [WIDTH-1:0] next_highPullUp;
   reg [WIDTH-1:0] next_regRdata;
   reg next_regRvalid;

   // Mode forcing and read mixing
   reg [WIDTH-1:0] lowEffDir;
   reg [WIDTH-1:0] highEffDir;
   reg [WIDTH-1:0] lowReadMix;
   reg [WIDTH-1:0] highReadMix;

   // Mode and address decode
   wire expanded;
   wire highFull;
   wire highSplit;
   wire highAddrMode;
   wire pullUpBlock;
   wire lowDirSel;
   wire lowDataSel;
   wire highDirSel;
   wire highDataSel;
   wire lowDirWr;
   wire lowDataWr;
   wire highDirWr;
   wire highDataWr;

   // Bitwise mix of latch and live pin by direction
   function [WIDTH-1:0] mixRead;
      input [WIDTH-1:0] dir;
      input [WIDTH-1:0] latch;
      input [WIDTH-1:0] pin;
      begin
         mixRead = (dir & latch) | (~dir & pin);
      end
   endfunction

   // Direction seen by the pins: all ones where the mode fixes it
   function [WIDTH-1:0] forceDir;
      input fixOnes;
      input [WIDTH-1:0] dir;
      begin
         forceDir = fixOnes ? {WIDTH{1'b1}} : dir;
      end
   endfunction

   // True when the mode code is either of two codes
   function isPair;
      input [2:0] code;
      input [2:0] first;
      input [2:0] second;
      begin
         isPair = (code == first) || (code == second);
      end
   endfunction

   // True in any of the four expanded modes
   function isExpanded;
      input [2:0] code;
      begin
         isExpanded = isPair(code, `DPIO_MODE1, `DPIO_MODE3) ||
                      isPair(code, `DPIO_MODE2, `DPIO_MODE4);
      end
   endfunction

   // True when the register address selects the given location
   function addrHit;
      input [15:0] addr;
      input [15:0] target;
      begin
         addrHit = (addr == target);
      end
   endfunction

   // Mode decode
   assign expanded = isExpanded(mode);
   assign highFull = isPair(mode, `DPIO_MODE1, `DPIO_MODE3);
   assign highSplit = isPair(mode, `DPIO_MODE2, `DPIO_MODE4);
   assign highAddrMode = highFull | highSplit;
   assign pullUpBlock = highFull | hwStandby;

   // Register address decode and write strobes
   assign lowDirSel = addrHit(regAddr, `DPIO_LOW_DIR_ADDR);
   assign lowDataSel = addrHit(regAddr, `DPIO_LOW_DATA_ADDR);
   assign highDirSel = addrHit(regAddr, `DPIO_HIGH_DIR_ADDR);
   assign highDataSel = addrHit(regAddr, `DPIO_HIGH_DATA_ADDR);
   assign lowDirWr = regWrite & lowDirSel;
   assign lowDataWr = regWrite & lowDataSel;
   assign highDirWr = regWrite & highDirSel;
   assign highDataWr = regWrite & highDataSel;

   dpio_sync #(.WIDTH(WIDTH)) lowSync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .asyncIn(lowPinIn),
      .syncOut(lowPinSync)
   );

   dpio_sync #(.WIDTH(WIDTH)) highSync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .asyncIn(highPinIn),
      .syncOut(highPinSync)
   );

   // Low direction: cleared by hardware standby, untouched by software standby
   always @* begin
      next_lowDir = lowDir;
      if (hwStandby) begin
         next_lowDir = `DPIO_DIR_RESET;
      end else if (lowDirWr) begin
         next_lowDir = regWdata;
      end
   end

   // Low data latch
   always @* begin
      next_lowData = lowData;
      if (hwStandby) begin
         next_lowData = `DPIO_DATA_RESET;
      end else if (lowDataWr) begin
         next_lowData = regWdata;
      end
   end

   // High direction: cleared by hardware standby, untouched by software standby
   always @* begin
      next_highDir = highDir;
      if (hwStandby) begin
         next_highDir = `DPIO_DIR_RESET;
      end else if (highDirWr) begin
         next_highDir = regWdata;
      end
   end

   // High data latch
   always @* begin
      next_highData = highData;
      if (hwStandby) begin
         next_highData = `DPIO_DATA_RESET;
      end else if (highDataWr) begin
         next_highData = regWdata;
      end
   end

   // Register state
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lowDir <= `DPIO_DIR_RESET;
         lowData <= `DPIO_DATA_RESET;
         highDir <= `DPIO_DIR_RESET;
         highData <= `DPIO_DATA_RESET;
      end else begin
         lowDir <= next_lowDir;
         lowData <= next_lowData;
         highDir <= next_highDir;
         highData <= next_highData;
      end
   end

   // Mode forcing of direction and read mixing
   always @* begin
      lowEffDir = forceDir(expanded, lowDir);
      highEffDir = forceDir(highFull, highDir);
      lowReadMix = mixRead(lowEffDir, lowData, lowPinSync);
      highReadMix = mixRead(highEffDir, highData, highPinSync);
   end

   // Low port: address byte in expanded modes, plain port otherwise
   always @* begin
      if (expanded) begin
         next_lowPinOut = busAddr[7:0];
      end else begin
         next_lowPinOut = lowData;
      end
      next_lowPinOe = lowEffDir;
   end

   // High port: address byte in modes 1 to 4, driven only on direction-output pins in modes 2 and 4
   always @* begin
      if (highAddrMode) begin
         next_highPinOut = busAddr[15:8];
      end else begin
         next_highPinOut = highData;
      end
      next_highPinOe = highEffDir;
   end

   // Pull-ups: off in modes 1 and 3 and in hardware standby
   always @* begin
      if (pullUpBlock) begin
         next_highPullUp = {WIDTH{1'b0}};
      end else begin
         next_highPullUp = ~highDir & highData;
      end
   end

   // Read data: direction registers read as all ones, held between reads
   always @* begin
      if (lowDirSel || highDirSel) begin
         next_regRdata = `DPIO_DIR_READ;
      end else if (lowDataSel) begin
         next_regRdata = lowReadMix;
      end else if (highDataSel) begin
         next_regRdata = highReadMix;
      end else begin
         next_regRdata = `DPIO_UNMAPPED_READ;
      end
      if (!regRead) begin
         next_regRdata = regRdata;
      end
      next_regRvalid = regRead;
   end

   // Low port pins
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lowPinOut <= {WIDTH{1'b0}};
         lowPinOe <= {WIDTH{1'b0}};
      end else begin
         lowPinOut <= next_lowPinOut;
         lowPinOe <= next_lowPinOe;
      end
   end

   // High port pins and pull-ups
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         highPinOut <= {WIDTH{1'b0}};
         highPinOe <= {WIDTH{1'b0}};
         highPullUp <= {WIDTH{1'b0}};
      end else begin
         highPinOut <= next_highPinOut;
         highPinOe <= next_highPinOe;
         highPullUp <= next_highPullUp;
      end
   end

   // Read port
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= {WIDTH{1'b0}};
         regRvalid <= 1'b0;
      end else begin
         regRdata <= next_regRdata;
         regRvalid <= next_regRvalid;
      end
   end
endmodule // dpio_ports

// [dpio_ports_props.sv]
/* Port checker for dpio_ports.
 Assumes mode changes only between register accesses. */
`timescale 1ns/100ps
module dpio_ports_props (
   input wire ref_clk,
   input wire arst_n,
   input wire hwStandby,
   input wire [2:0] mode,
   input wire [15:0] busAddr,
   input wire [15:0] regAddr,
   input wire regRead,
   input wire [7:0] regRdata,
   input wire regRvalid,
   input wire [7:0] lowPinOut,
   input wire [7:0] lowPinOe,
   input wire [7:0] highPinOut,
   input wire [7:0] highPinOe,
   input wire [7:0] highPullUp
);
   logic [15:0] prevAddr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   always @(posedge ref_clk) prevAddr <= busAddr;
   property p_rv; regRead |=> regRvalid; endproperty
   a_rv: assert property (p_rv) else $error("read not answered");
   property p_nrv; !regRead |=> !regRvalid; endproperty
   a_nrv: assert property (p_nrv) else $error("stray read valid");
   property p_dr; regRead && (regAddr == 16'hFF85 || regAddr == 16'hFF88) |=> regRdata == 8'hFF; endproperty
   a_dr: assert property (p_dr) else $error("direction read not all ones");
   property p_lexp;
      mode inside {3'h1, 3'h2, 3'h3, 3'h4} |=> lowPinOe == 8'hFF && lowPinOut == prevAddr[7:0];
   endproperty
   a_lexp: assert property (p_lexp) else $error("low port not on address");
   property p_h13;
      mode == 3'h1 || mode == 3'h3 |=> highPinOe == 8'hFF && highPinOut == prevAddr[15:8] && highPullUp == 8'h00;
   endproperty
   a_h13: assert property (p_h13) else $error("high port not on address");
   property p_h24; mode == 3'h2 || mode == 3'h4 |=> ((highPinOut ^ prevAddr[15:8]) & highPinOe) == 8'h00; endproperty
   a_h24: assert property (p_h24) else $error("high output pin not on address");
   property p_hws; hwStandby && mode == 3'h7 |-> ##2 (lowPinOe | highPinOe) == 8'h00; endproperty
   a_hws: assert property (p_hws) else $error("standby left an output");
   property p_pu; hwStandby |-> ##2 highPullUp == 8'h00; endproperty
   a_pu: assert property (p_pu) else $error("pull-up on in standby");
   c_exp: cover property (mode == 3'h2 && highPinOe != 8'h00);
   c_hws: cover property (hwStandby ##1 !hwStandby);
   c_rd: cover property (regRvalid && regRdata != 8'hFF);
endmodule // dpio_ports_props
bind dpio_ports dpio_ports_props chk (.*);

// [dpio_sync.v]
/*
 Two-flop synchroniser for a vector of pin inputs.
 Assumes the pins are asynchronous to ref_clk.
*/
`timescale 1ns/100ps
module dpio_sync #(
   parameter WIDTH = 8
) (
   input wire ref_clk,
   input wire arst_n,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stageOne;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stageOne <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule // dpio_sync

// [tb.sv]
/* Self-checking bench for dpio_ports.
 Assumes the pin models drive all released pins. */
`timescale 1ns/100ps
module tb;
   logic ref_clk = 0, arst_n = 0, hwStandby = 0, softStandby = 0, regWrite = 0, regRead = 0, regRvalid;
   logic [2:0] mode = 3'h7;
   logic [15:0] busAddr = 0, regAddr = 0;
   logic [7:0] regWdata = 0, regRdata, lowPinIn, lowPinOut, lowPinOe, highPinIn, highPinOut, highPinOe, highPullUp;
   logic [7:0] extLow = 0, extHigh = 0, d, v, q;
   int errors = 0, cmp_count = 0, cyc = 0, p, m;
   initial forever #2 ref_clk = ~ref_clk;
   dpio_ports uut (.*);
   dpio_ext_pins lowExt (.pinOut(lowPinOut), .pinOe(lowPinOe), .extDrive(extLow), .pinLevel(lowPinIn));
   dpio_ext_pins highExt (.pinOut(highPinOut), .pinOe(highPinOe), .extDrive(extHigh), .pinLevel(highPinIn));
   function logic [7:0] mix(logic [7:0] dd, vv, ee);
      return (dd & vv) | (~dd & ee);
   endfunction
   task report_and_stop;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(string n, logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(logic [15:0] a, logic [7:0] w);
      regAddr = a;
      regWdata = w;
      regWrite = 1;
      @(posedge ref_clk) #1 regWrite = 0;
      @(posedge ref_clk) #1;
   endtask
   task rd(logic [15:0] a, logic [7:0] e);
      regAddr = a;
      regRead = 1;
      @(posedge ref_clk) #1 regRead = 0;
      chk("rvalid", {7'h0, regRvalid}, 8'h01);
      chk("rdata", regRdata, e);
      @(posedge ref_clk) #1;
      chk("rvalidEnd", {7'h0, regRvalid}, 8'h00);
   endtask
   task cleared;
      chk("oe", lowPinOe | highPinOe, 8'h00);
      chk("pullUp", highPullUp, 8'h00);
      wr(16'hFF85, 8'hFF);
      wr(16'hFF88, 8'hFF);
      rd(16'hFF87, 8'h00);
      rd(16'hFF8A, 8'h00);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 3000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      void'($urandom(83));
      repeat (6) @(posedge ref_clk);
      #1 arst_n = 1;
      rd(16'hFF85, 8'hFF);
      rd(16'hFF88, 8'hFF);
      rd(16'hFF90, 8'hFF);
      cleared;
      repeat (20) for (p = 0; p < 2; p++) begin
         d = 8'($urandom);
         v = 8'($urandom);
         q = 8'($urandom);
         busAddr = 16'($urandom);
         softStandby = 1'($urandom);
         if (p == 1) extHigh = q;
         else extLow = q;
         wr(p ? 16'hFF88 : 16'hFF85, d);
         wr(p ? 16'hFF8A : 16'hFF87, v);
         repeat (2) @(posedge ref_clk) #1;
         rd(p ? 16'hFF8A : 16'hFF87, mix(d, v, q));
         chk("oe", p ? highPinOe : lowPinOe, d);
         chk("out", (p ? highPinOut : lowPinOut) & d, v & d);
         if (p == 1) chk("pullUp", highPullUp, ~d & v);
      end
      hwStandby = 1;
      repeat (2) @(posedge ref_clk) #1;
      hwStandby = 0;
      cleared;
      for (m = 1; m < 5; m++) begin
         mode = m[2:0];
         busAddr = 16'($urandom);
         d = 8'($urandom);
         wr(16'hFF85, 8'h00);
         wr(16'hFF88, d);
         wr(16'hFF8A, 8'hFF);
         rd(16'hFF87, 8'h00);
         chk("lowOe", lowPinOe, 8'hFF);
         chk("lowOut", lowPinOut, busAddr[7:0]);
         if (m % 2) begin
            chk("highOe", highPinOe, 8'hFF);
            chk("highOut", highPinOut, busAddr[15:8]);
            chk("pullUp", highPullUp, 8'h00);
            rd(16'hFF8A, 8'hFF);
         end else begin
            rd(16'hFF8A, mix(d, 8'hFF, extHigh));
            chk("highOe", highPinOe, d);
            chk("highOut", highPinOut & d, busAddr[15:8] & d);
            chk("pullUp", highPullUp, ~d);
         end
      end
      report_and_stop;
   end
endmodule // tb
